/* File: inc/dscr_pkg.sv */
// Purpose: constants and types for the decoder status/config register bank
// Assumes: 32-bit AXI4-Lite register window, one 8-bit register per word
// Notes: offsets are byte addresses; upper data bits read as zero
//
// Functional notes
// R01 - Four-bit next-mode preview: 0..7 give mode, top bit means >7 or error
// R02 - Preview top bit ORs mode bits 7..3; erasure forces every bit high
// R03 - Reading status register three clears a pending decoder interrupt
// R04 - Invalid bit reads 0 after interrupt, 1 once all decoder regs read
// R05 - Status bit 5 shows ECC performed on the current block
// R06 - Any reset-register write reinitialises registers and picks host mode
// R07 - Hardware reset loads host-select with all ones
// R08 - After hardware reset stay idle until host mode is written
// R09 - After hardware reset pins float unless host read strobe is low
// R10 - Host-select 000 compat A, 001 ATAPI, 010 compat B, 011 float
// R11 - Ten-bit subcode block address held in low and high registers
// R12 - Config bit 7 selects serial format: 0 I2S, 1 EIAJ
// R13 - Config bits 6,5 select oversampling: none, twofold, fourfold
// R14 - Config bit 4 selects subcode format: 0 format A, 1 EIAJ
// R15 - Config bit 3 enables the Q-to-W subcode port
// R16 - Config bit 2 selects raw subcode, clear means cooked
// R17 - Config bit 1 puts external buffer RAM in test mode
// R18 - Serial bit clock is the timing reference for subcode recovery
// R19 - Software must program oversampling matching the DAC serial rate
// R20 - Unused bits of status three and config read zero, ignore writes
package dscr_pkg;

  localparam int AXI_AW = 8;
  localparam int REG_W = 8;
  localparam int SUB_AW = 10;
  localparam int SUB_LO_W = 8;
  localparam int HSEL_W = 3;

  localparam logic [7:0] OFF_STATUS3 = 8'h00;
  localparam logic [7:0] OFF_PREVIEW = 8'h04;
  localparam logic [7:0] OFF_RESET = 8'h08;
  localparam logic [7:0] OFF_SUB_LO = 8'h0C;
  localparam logic [7:0] OFF_SUB_HI = 8'h10;
  localparam logic [7:0] OFF_INCFG = 8'h14;
  localparam logic [7:0] OFF_HOST = 8'h18;

  localparam int DECODER_STATUS_THREE_INVALID_BIT = 7;
  localparam int DECODER_STATUS_THREE_ECC_BIT = 5;
  localparam int PREVIEW_TOP_BIT = 3;
  localparam int HOST_LIVE_BIT = 7;

  localparam logic [HSEL_W-1:0] HSEL_HW_RESET = 3'h7;
  localparam logic [HSEL_W-1:0] HSEL_COMPAT_A = 3'h0;
  localparam logic [HSEL_W-1:0] HSEL_ATAPI = 3'h1;
  localparam logic [HSEL_W-1:0] HSEL_COMPAT_B = 3'h2;
  localparam logic [HSEL_W-1:0] HSEL_FLOAT = 3'h3;

  localparam logic [SUB_AW-1:0] SUB_RESET = 10'h000;
  localparam logic [6:0] INCFG_RESET = 7'h00;
  localparam logic INVALID_RESET = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    HM_COMPAT_A = 5'b0_0001,
    HM_ATAPI = 5'b0_0010,
    HM_COMPAT_B = 5'b0_0100,
    HM_FLOAT = 5'b0_1000,
    HM_RESERVED = 5'b1_0000
  } dscr_host_mode_t;

  typedef enum logic [1:0] {
    LF_WAIT_SELECT = 2'b01,
    LF_RUN = 2'b10
  } dscr_life_t;

  typedef enum logic [2:0] {
    OS_NONE = 3'b001,
    OS_X2 = 3'b010,
    OS_X4 = 3'b100
  } dscr_oversample_t;

  // Bit order matches config register bits 7 down to 1
  typedef struct packed {
    logic serial_format_select;
    logic oversample_sel_hi;
    logic oversample_sel_lo;
    logic subcode_format_select;
    logic subcode_port_enable;
    logic subcode_raw_select;
    logic buffer_ram_test;
  } dscr_incfg_t;

  typedef struct packed {
    logic block_event;
    logic ecc_performed;
    logic [7:0] next_mode_byte;
    logic erasure_flag;
  } dscr_dec_in_t;

endpackage

/* File: logic/dscr_regs.sv */
// Purpose: decoder status, soft reset/host select, subcode address and
//   input path configuration registers behind an AXI4-Lite slave
// Assumes: decoder inputs share clk; host read strobe and serial bit
//   clock are pins and pass two flip-flops first
// Notes: one write and one read in flight; reads answer one cycle after taking, writes two
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dscr_regs
  import dscr_pkg::*;
#(
  parameter int ADDR_W = AXI_AW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dscr_dec_in_t dec_in,
  input wire logic host_read_strobe_n,
  input wire logic serial_bit_clock,
  output logic decoder_interrupt,
  output logic regs_invalid_flag,
  output logic ecc_done_flag,
  output logic [3:0] next_mode_preview,
  output logic soft_reset_pulse,
  output logic device_idle,
  output dscr_host_mode_t host_mode,
  output logic host_pins_oe,
  output logic [SUB_AW-1:0] subcode_block_address,
  output dscr_incfg_t input_path_config,
  output dscr_oversample_t oversample_factor,
  output logic subcode_bit_tick
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("dscr_regs: ADDR_W must lie between 8 and 32");
  end

  typedef struct packed {
    dscr_life_t life;
    logic [HSEL_W-1:0] hsel;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [REG_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic invalid;
    logic ecc;
    logic [3:0] preview;
    logic [1:0] read_mask;
    logic [SUB_AW-1:0] sub_addr;
    dscr_incfg_t cfg;
    logic srst;
    logic pins_oe;
    logic hrd_meta;
    logic hrd_sync;
    logic bck_meta;
    logic bck_sync;
    logic bck_prev;
    logic [1:0] bck_cnt;
    logic tick;
  } dscr_state_t;

  dscr_state_t s;
  dscr_state_t next_s;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    logic [ADDR_W-1:0] o;
    o = ADDR_W'(off);
    return a[ADDR_W-1:2] == o[ADDR_W-1:2];
  endfunction

  function automatic dscr_host_mode_t decode_hsel(
      input logic [HSEL_W-1:0] h);
    dscr_host_mode_t m;
    case (h)
      HSEL_COMPAT_A: m = HM_COMPAT_A; // R10
      HSEL_ATAPI: m = HM_ATAPI; // R10
      HSEL_COMPAT_B: m = HM_COMPAT_B; // R10
      HSEL_FLOAT: m = HM_FLOAT; // R10
      default: m = HM_RESERVED;
    endcase
    return m;
  endfunction

  function automatic dscr_oversample_t decode_os(input dscr_incfg_t c);
    dscr_oversample_t f;
    case ({c.oversample_sel_hi, c.oversample_sel_lo})
      2'b01: f = OS_X2; // R13
      2'b10: f = OS_X4; // R13
      default: f = OS_NONE; // R13
    endcase
    return f;
  endfunction

  // Read view of each register; unmapped words give zero
  function automatic logic [REG_W-1:0] read_view(
      input dscr_state_t st, input logic [ADDR_W-1:0] a);
    logic [REG_W-1:0] v;
    v = '0;
    if (hit(a, OFF_STATUS3)) begin
      v[DECODER_STATUS_THREE_INVALID_BIT] = st.invalid; // R04
      v[DECODER_STATUS_THREE_ECC_BIT] = st.ecc; // R05
    end else if (hit(a, OFF_PREVIEW)) begin
      v[3:0] = st.preview; // R01
    end else if (hit(a, OFF_SUB_LO)) begin
      v = st.sub_addr[SUB_LO_W-1:0]; // R11
    end else if (hit(a, OFF_SUB_HI)) begin
      v[SUB_AW-SUB_LO_W-1:0] = st.sub_addr[SUB_AW-1:SUB_LO_W]; // R11
    end else if (hit(a, OFF_INCFG)) begin
      v = {st.cfg, 1'b0}; // R20
    end else if (hit(a, OFF_HOST)) begin
      v[HOST_LIVE_BIT] = (st.life == LF_RUN);
      v[HSEL_W-1:0] = st.hsel;
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, OFF_STATUS3) || hit(a, OFF_PREVIEW) ||
           hit(a, OFF_RESET) || hit(a, OFF_SUB_LO) ||
           hit(a, OFF_SUB_HI) || hit(a, OFF_INCFG) || hit(a, OFF_HOST);
  endfunction

  logic bck_rise;
  logic [1:0] bck_last;
  logic do_write;
  logic read_take;

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h00_0000, s.rdata};

  assign do_write = s.aw_held && s.w_held;
  assign read_take = s_axi_arvalid && !s.rvalid;
  assign bck_rise = s.bck_sync && !s.bck_prev;

  always_comb begin
    case (decode_os(s.cfg))
      OS_X2: bck_last = 2'd1;
      OS_X4: bck_last = 2'd3;
      default: bck_last = 2'd0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.srst = 1'b0;
    next_s.tick = 1'b0;

    // Pin synchronisers
    next_s.hrd_meta = host_read_strobe_n;
    next_s.hrd_sync = s.hrd_meta;
    next_s.bck_meta = serial_bit_clock;
    next_s.bck_sync = s.bck_meta;
    next_s.bck_prev = s.bck_sync;

    // Subcode bit timing follows the serial bit clock, slowed by the
    // programmed oversampling so one tick marks one disc data bit
    if (!s.cfg.subcode_port_enable) begin // R15
      next_s.bck_cnt = 2'd0;
    end else if (bck_rise) begin // R18
      if (s.bck_cnt >= bck_last) begin // R19
        next_s.bck_cnt = 2'd0;
        next_s.tick = 1'b1;
      end else begin
        next_s.bck_cnt = s.bck_cnt + 2'd1;
      end
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata[REG_W-1:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Reads; a read of status three acknowledges the interrupt
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (read_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_view(s, s_axi_araddr);
      next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (hit(s_axi_araddr, OFF_STATUS3)) begin
        next_s.irq = 1'b0; // R03
        next_s.read_mask[0] = 1'b1; // R04
      end
      if (hit(s_axi_araddr, OFF_PREVIEW)) begin
        next_s.read_mask[1] = 1'b1; // R04
      end
    end

    // Register set turns invalid only once every part has been read
    if (!s.invalid && (&s.read_mask)) begin
      next_s.invalid = 1'b1; // R04
    end

    // A new block outranks a same-cycle acknowledge; no block event
    // is taken until a host mode has been chosen
    if (dec_in.block_event && s.life == LF_RUN) begin // R08
      next_s.irq = 1'b1;
      next_s.invalid = 1'b0; // R04
      next_s.read_mask = 2'b00;
      next_s.ecc = dec_in.ecc_performed; // R05
      for (int i = 0; i < PREVIEW_TOP_BIT; i++) begin
        next_s.preview[i] =
          dec_in.next_mode_byte[i] | dec_in.erasure_flag; // R02
      end
      next_s.preview[PREVIEW_TOP_BIT] =
        (|dec_in.next_mode_byte[7:PREVIEW_TOP_BIT]) |
        dec_in.erasure_flag; // R02
    end

    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (s.w_lane0) begin
        if (hit(s.aw_addr, OFF_SUB_LO)) begin
          next_s.sub_addr[SUB_LO_W-1:0] = s.w_data; // R11
        end
        if (hit(s.aw_addr, OFF_SUB_HI)) begin
          next_s.sub_addr[SUB_AW-1:SUB_LO_W] =
            s.w_data[SUB_AW-SUB_LO_W-1:0]; // R11
        end
        if (hit(s.aw_addr, OFF_INCFG)) begin
          next_s.cfg = s.w_data[REG_W-1:1]; // R20
        end
        // Device-wide restart wins over any event landing with it
        if (hit(s.aw_addr, OFF_RESET)) begin
          next_s.srst = 1'b1; // R06
          next_s.hsel = s.w_data[HSEL_W-1:0]; // R06
          next_s.life = LF_RUN; // R08
          next_s.irq = 1'b0;
          next_s.invalid = INVALID_RESET;
          next_s.ecc = 1'b0;
          next_s.preview = 4'h0;
          next_s.read_mask = 2'b00;
          next_s.sub_addr = SUB_RESET;
          next_s.cfg = INCFG_RESET;
          next_s.bck_cnt = 2'd0;
        end
      end
    end

    // Pin drive: before a mode exists, only a low read strobe drives
    case (s.life)
      LF_WAIT_SELECT: next_s.pins_oe = !s.hrd_sync; // R09
      LF_RUN: begin
        case (decode_hsel(s.hsel))
          HM_COMPAT_A, HM_ATAPI, HM_COMPAT_B: next_s.pins_oe = 1'b1;
          default: next_s.pins_oe = 1'b0; // R10
        endcase
      end
      default: next_s.pins_oe = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.life <= LF_WAIT_SELECT; // R08
      s.hsel <= HSEL_HW_RESET; // R07
      s.invalid <= INVALID_RESET;
      s.sub_addr <= SUB_RESET;
      s.cfg <= INCFG_RESET;
      s.hrd_meta <= 1'b1;
      s.hrd_sync <= 1'b1;
      s.rresp <= RESP_OKAY;
      s.bresp <= RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  assign decoder_interrupt = s.irq;
  assign regs_invalid_flag = s.invalid;
  assign ecc_done_flag = s.ecc;
  assign next_mode_preview = s.preview;
  assign soft_reset_pulse = s.srst;
  assign device_idle = (s.life == LF_WAIT_SELECT);
  assign host_mode = decode_hsel(s.hsel);
  assign host_pins_oe = s.pins_oe;
  assign subcode_block_address = s.sub_addr;
  assign input_path_config = s.cfg; // R12 R13 R14 R15 R16 R17
  assign oversample_factor = decode_os(s.cfg);
  assign subcode_bit_tick = s.tick;

endmodule

`default_nettype wire

/* File: sim/dscr_regs_chk.sv */
// Purpose: port-level assertions for the decoder status/config registers
// Assumes: single clock domain, rst_n async active low
// Notes: sees only top-level ports, attached by bind
`timescale 1ns/1ps
`default_nettype none
module dscr_regs_chk
  import dscr_pkg::*;
#(
  parameter int ADDR_W = AXI_AW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire dscr_dec_in_t dec_in,
  input wire logic host_read_strobe_n,
  input wire logic decoder_interrupt,
  input wire logic regs_invalid_flag,
  input wire logic ecc_done_flag,
  input wire logic [3:0] next_mode_preview,
  input wire logic soft_reset_pulse,
  input wire logic device_idle,
  input wire dscr_host_mode_t host_mode,
  input wire logic host_pins_oe,
  input wire dscr_incfg_t input_path_config,
  input wire dscr_oversample_t oversample_factor,
  input wire logic subcode_bit_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ev;
  logic rd3;
  logic [3:0] pv;
  assign ev = dec_in.block_event && !device_idle;
  assign rd3 = s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == 0;
  assign pv = {|dec_in.next_mode_byte[7:3], dec_in.next_mode_byte[2:0]}
    | {4{dec_in.erasure_flag}};
  a_evt_flags: assert property (ev |=> decoder_interrupt
    && !regs_invalid_flag && ecc_done_flag == $past(dec_in.ecc_performed))
    else $error("event flags wrong");
  a_preview_form: assert property (ev |=>
    next_mode_preview == $past(pv))
    else $error("mode preview wrong");
  a_irq_clear: assert property (rd3 && !ev |=> !decoder_interrupt)
    else $error("status read kept interrupt");
  a_idle_event: assert property (device_idle && !decoder_interrupt
    && dec_in.block_event |=> !decoder_interrupt)
    else $error("event taken while idle");
  a_srst_pulse: assert property (soft_reset_pulse |=>
    !soft_reset_pulse && !device_idle)
    else $error("soft reset pulse wrong");
  a_host_oe: assert property (!device_idle && $stable(host_mode) |=>
    host_pins_oe == ($past(host_mode) inside {HM_COMPAT_A, HM_ATAPI,
    HM_COMPAT_B}))
    else $error("host pin enable wrong");
  a_idle_float: assert property (device_idle && host_read_strobe_n [*4]
    |-> !host_pins_oe)
    else $error("pins driven while idle");
  a_os_decode: assert property (oversample_factor ==
    ((input_path_config.oversample_sel_hi
    && !input_path_config.oversample_sel_lo)
    ? OS_X4 : (input_path_config.oversample_sel_lo
    && !input_path_config.oversample_sel_hi) ? OS_X2 : OS_NONE))
    else $error("oversample decode wrong");
  a_tick_off: assert property (
    !input_path_config.subcode_port_enable [*5] |-> !subcode_bit_tick)
    else $error("tick while port off");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 0)
    else $error("read answer wrong");
  // A pending response must hold off both write channels
  a_wr_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  c_event: cover property (ev);
  c_srst: cover property (soft_reset_pulse);
  c_tick: cover property (subcode_bit_tick);
endmodule
bind dscr_regs dscr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
  .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .dec_in(dec_in),
  .host_read_strobe_n(host_read_strobe_n),
  .decoder_interrupt(decoder_interrupt), .regs_invalid_flag(regs_invalid_flag),
  .ecc_done_flag(ecc_done_flag), .next_mode_preview(next_mode_preview),
  .soft_reset_pulse(soft_reset_pulse), .device_idle(device_idle),
  .host_mode(host_mode), .host_pins_oe(host_pins_oe),
  .input_path_config(input_path_config), .oversample_factor(oversample_factor),
  .subcode_bit_tick(subcode_bit_tick));
`default_nettype wire

/* File: sim/dscr_bck_model.sv */
// Purpose: serial bit clock source on the decoder's input side
// Assumes: bit clock far slower than clk, 16 clk per period
// Notes: clock stands low between bursts, as the far side does
`timescale 1ns/1ps
`default_nettype none
module dscr_bck_model #(
  parameter int EDGES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic serial_bit_clock
);
  logic [3:0] ph;
  logic [7:0] left;
  // Timing reference for subcode recovery comes in bursts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 4'h0;
      left <= 8'h00;
      serial_bit_clock <= 1'b0;
    end else if (start && left == 8'h00) begin
      left <= 8'(EDGES);
      ph <= 4'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 4'h1;
      if (ph == 4'h7) serial_bit_clock <= 1'b1;
      if (ph == 4'hf) begin
        serial_bit_clock <= 1'b0;
        left <= left - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the decoder register bank
// Assumes: AXI4-Lite master tasks, inputs changed just after posedge
// Notes: handshakes judged at negedge, where values equal the next edge
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dscr_pkg::*;
;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic awr, wr_, bv, arr, rv, hrd_n = 1, go = 0, sbc, irq, inval, ecc;
  logic srst, idle, oe, tick;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [3:0] ws = 0, pv;
  logic [1:0] bresp, rresp;
  logic [9:0] sub;
  dscr_dec_in_t dec = '0;
  dscr_host_mode_t hm;
  dscr_incfg_t cfg;
  dscr_oversample_t osf;
  int n_mismatch = 0, checks_done = 0;
  int n_srst = 0;
  // Counts soft reset pulses; the pulse spans exactly one edge
  always @(posedge clk) begin
    if (srst === 1'b1) n_srst++;
  end
  always #2.5 clk = ~clk;
  dscr_regs dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .dec_in(dec),
    .host_read_strobe_n(hrd_n), .serial_bit_clock(sbc),
    .decoder_interrupt(irq), .regs_invalid_flag(inval), .ecc_done_flag(ecc),
    .next_mode_preview(pv), .soft_reset_pulse(srst), .device_idle(idle),
    .host_mode(hm), .host_pins_oe(oe), .subcode_block_address(sub),
    .input_path_config(cfg), .oversample_factor(osf), .subcode_bit_tick(tick));
  dscr_bck_model bck (.clk(clk), .rst_n(rst_n), .start(go),
    .serial_bit_clock(sbc));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hang();
    n_mismatch++;
    $display("BAD %0t got %h exp %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a; wd <= d; ws <= 4'h1; awv <= 1; wv <= 1; brd <= 1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wr_; tb = bv && brd;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) begin
        brd <= 0;
        chk(32'(bresp), 32'(er));
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    ara <= a; arv <= 1; rrd <= 1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      ta = arv && arr; tb = rv && rrd; d = rdat; r = rresp;
      @(posedge clk);
      if (ta) arv <= 0;
      if (tb) begin
        rrd <= 0;
        chk(d, ed);
        chk(32'(r), 32'(er));
        return;
      end
    end
    hang();
  endtask
  task automatic evt(input logic [7:0] m, input logic e, input logic c);
    @(posedge clk);
    dec <= '{1'b1, c, m, e};
    @(posedge clk);
    dec.block_event <= 1'b0;
  endtask
  localparam logic [1:0] OK = RESP_OKAY;
  dscr_oversample_t osx [4] = '{OS_NONE, OS_X2, OS_X4, OS_NONE};
  logic [7:0] cv [4] = '{8'h08, 8'h28, 8'h48, 8'h00};
  logic [7:0] mv [4] = '{8'h05, 8'h07, 8'h08, 8'h02};
  initial begin
    logic [3:0] ep;
    int nt;
    cyc(2);
    rst_n <= 1;
    rd(8'h00, 32'h80, OK);
    rd(8'h18, 32'h07, OK);
    evt(8'h01, 1'b0, 1'b1);
    cyc(2);
    chk(32'(irq), 0);
    chk(32'(idle), 1);
    chk(32'(oe), 0);
    hrd_n <= 0;
    cyc(5);
    chk(32'(oe), 1);
    hrd_n <= 1;
    $display("test 1 done");
    wr(8'h14, 32'hfe, OK);
    wr(8'h0c, 32'h55, OK);
    // Descending so the run goes on in a live host mode
    for (int i = 4; i >= 0; i--) begin
      wr(8'h08, 32'(i), OK);
      cyc(3);
      chk(32'(hm), 32'h1 << i);
      chk(32'(oe), 32'(i < 3));
      rd(8'h18, 32'h80 | 32'(i), OK);
    end
    rd(8'h14, 0, OK);
    rd(8'h0c, 0, OK);
    chk(32'(n_srst), 32'h5);
    $display("test 2 done");
    wr(8'h0c, 32'ha5, OK);
    wr(8'h10, 32'hff, OK);
    rd(8'h10, 32'h03, OK);
    chk(32'(sub), 32'h3a5);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    rd(8'h1c, 0, RESP_SLVERR);
    wr(8'h00, 32'hff, OK);
    rd(8'h00, 32'h80, OK);
    for (int i = 1; i < 8; i++) begin
      wr(8'h14, 32'h1 << i, OK);
      rd(8'h14, 32'h1 << i, OK);
      chk(32'(cfg), 32'h1 << (i - 1));
    end
    wr(8'h14, 32'hff, OK);
    rd(8'h14, 32'hfe, OK);
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, 32'(i << 5), OK);
      cyc(1);
      chk(32'(osf), 32'(osx[i]));
    end
    $display("test 3 done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, 0, OK);
      wr(8'h14, 32'(cv[i]), OK);
      go <= 1;
      @(posedge clk);
      go <= 0;
      nt = 0;
      repeat (200) begin
        @(negedge clk);
        if (tick === 1'b1) nt++;
      end
      chk(32'(nt), 32'(i == 3 ? 0 : 8 >> i));
    end
    $display("test 4 done");
    for (int i = 0; i < 4; i++) begin
      ep = {|mv[i][7:3], mv[i][2:0]} | {4{i == 3}};
      evt(mv[i], i == 3, i[0]);
      cyc(2);
      chk(32'(irq), 1);
      chk(32'(inval), 0);
      chk(32'(pv), 32'(ep));
      chk(32'(ecc), 32'(i[0]));
      rd(8'h00, 32'(i[0]) << 5, OK);
      chk(32'(irq), 0);
      chk(32'(inval), 0);
      rd(8'h04, 32'(ep), OK);
      cyc(2);
      chk(32'(inval), 1);
    end
    $display("test 5 done");
    print_verdict();
  end
endmodule
`default_nettype wire
